/* rcrm_pkg.sv */
// shared constants, types and decode function for the reference clock routing mux
//-----------------------------------------------------------------------------
// How it works
// - one of four reference clock sources drives the shared pll input.
// - software reselects the source at run time through the config port.
// - at most one clock travels northward through a tile at once.
// - at most one clock travels southward through a tile at once.
// - forwarding works even when local transceivers ignore the forwarded clock.
// - overlapping clock regions are allowed when routed through the config port.
// - all selector fields live in the config port word at address 0x04.
// - source code lsb at bit 6, middle bit 5, msb bit 4.
// - downward route choice at bit 7, upward route choice at bit 8.
// - source code bits marked x are ignored by the multiplexer.
// - code 1x1 selects the clock arriving from the south.
// - upward choice 0 passes clock from south northward, 1 drives own clock.
// - downward choice 1 drives own clock southward, 0 passes clock from north.
//-----------------------------------------------------------------------------
package rcrm_pkg;

	//-------------------------------------------------------------------------
	// config port geometry
	//-------------------------------------------------------------------------
	localparam int          CFG_ADDR_W        = 7;
	localparam int          CFG_DATA_W        = 16;
	localparam logic [6:0]  ROUTE_SELECT_ADDR = 7'h04;
	localparam logic [15:0] ROUTE_SELECT_RST  = 16'h0000;
	localparam logic [15:0] UNMAPPED_RDATA    = 16'h0000;

	//-------------------------------------------------------------------------
	// field positions inside the route select word
	//-------------------------------------------------------------------------
	localparam int SRC_BIT0_POS  = 6;
	localparam int SRC_BIT1_POS  = 5;
	localparam int SRC_BIT2_POS  = 4;
	localparam int DOWN_SEL_POS  = 7;
	localparam int UP_SEL_POS    = 8;
	localparam logic [15:0] SELECTOR_MASK = 16'h01f0;

	//-------------------------------------------------------------------------
	// access timing: cycles spent between request and ready
	//-------------------------------------------------------------------------
	localparam logic [1:0] ACCESS_CYCLES = 2'h2;

	//-------------------------------------------------------------------------
	// types
	//-------------------------------------------------------------------------
	typedef struct packed {
		logic                  en;
		logic                  we;
		logic [CFG_ADDR_W-1:0] addr;
		logic [CFG_DATA_W-1:0] wdata;
	} rcrm_cfg_req_type;

	typedef enum logic [1:0] {
		SRC_LOCAL      = 2'b00,
		SRC_OWN        = 2'b01,
		SRC_FROM_NORTH = 2'b10,
		SRC_FROM_SOUTH = 2'b11
	} rcrm_source_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b10
	} rcrm_state_type;

	//-------------------------------------------------------------------------
	// source code decode, x positions ignored
	//-------------------------------------------------------------------------
	function automatic rcrm_source_type decode_source(input logic [2:0] code);
		rcrm_source_type src;
		if (!code[0]) begin
			src = SRC_LOCAL;
		end else if (code[2]) begin
			src = SRC_FROM_SOUTH;
		end else if (code[1]) begin
			src = SRC_OWN;
		end else begin
			src = SRC_FROM_NORTH;
		end
		return src;
	endfunction

	// pull the source code out of a route select word
	function automatic logic [2:0] extract_code(input logic [15:0] word);
		return {word[SRC_BIT2_POS], word[SRC_BIT1_POS], word[SRC_BIT0_POS]};
	endfunction

endpackage

/* rcrm_clock_mux.sv */
// reference clock multiplexer and north/south forwarding paths of one tile
module rcrm_clock_mux (
	input  wire logic       i_local_ref_clk,
	input  wire logic       i_own_ref_clk,
	input  wire logic       i_from_north_clk,
	input  wire logic       i_from_south_clk,
	input  wire logic [2:0] i_source_code,
	input  wire logic       i_upward_route_choice,
	input  wire logic       i_downward_route_choice,
	output logic            o_pll_input_clock,
	output logic            o_to_north_clk,
	output logic            o_to_south_clk
);

	//-------------------------------------------------------------------------
	// pll input selection
	//-------------------------------------------------------------------------
	rcrm_pkg::rcrm_source_type src;

	// one of four sources reaches the pll input
	always_comb begin
		src = rcrm_pkg::decode_source(i_source_code);
		unique case (src)
			rcrm_pkg::SRC_LOCAL:      o_pll_input_clock = i_local_ref_clk;
			rcrm_pkg::SRC_OWN:        o_pll_input_clock = i_own_ref_clk;
			rcrm_pkg::SRC_FROM_NORTH: o_pll_input_clock = i_from_north_clk;
			rcrm_pkg::SRC_FROM_SOUTH: o_pll_input_clock = i_from_south_clk;
		endcase
	end

	//-------------------------------------------------------------------------
	// forwarding paths, independent of pll selection
	//-------------------------------------------------------------------------
	// a single 2:1 per direction, so only one clock can ever leave each way
	always_comb begin
		o_to_north_clk = i_upward_route_choice ? i_own_ref_clk : i_from_south_clk;
		o_to_south_clk = i_downward_route_choice ? i_own_ref_clk : i_from_north_clk;
	end

endmodule

/* rcrm_route_top.sv */
// top of the reference clock routing block: config port slave, route word and mux
module rcrm_route_top (
	input  wire logic                         i_core_clk,
	input  wire logic                         i_rst,
	// config port
	input  wire rcrm_pkg::rcrm_cfg_req_type   i_cfg_req,
	output logic                              o_cfg_rdy,
	output logic [rcrm_pkg::CFG_DATA_W-1:0]   o_cfg_rdata,
	output logic                              o_cfg_busy,
	// tile reset seen by the block
	input  wire logic                         i_tile_reset,
	// reference clocks
	input  wire logic                         i_local_ref_clk,
	input  wire logic                         i_own_ref_clk,
	input  wire logic                         i_from_north_clk,
	input  wire logic                         i_from_south_clk,
	output logic                              o_pll_input_clock,
	output logic                              o_to_north_clk,
	output logic                              o_to_south_clk,
	// status
	output rcrm_pkg::rcrm_source_type         o_pll_source,
	output logic                              o_upward_route_choice,
	output logic                              o_downward_route_choice,
	output logic                              o_own_clock_exported,
	output logic                              o_route_changed
);

	//-------------------------------------------------------------------------
	// state
	//-------------------------------------------------------------------------
	rcrm_pkg::rcrm_state_type               state_r;
	rcrm_pkg::rcrm_state_type               state_nxt;
	logic [1:0]                             cnt_r;
	logic [1:0]                             cnt_nxt;
	rcrm_pkg::rcrm_cfg_req_type             req_r;
	rcrm_pkg::rcrm_cfg_req_type             req_nxt;
	logic [rcrm_pkg::CFG_DATA_W-1:0]        route_word_r;
	logic [rcrm_pkg::CFG_DATA_W-1:0]        route_word_nxt;
	logic [rcrm_pkg::CFG_DATA_W-1:0]        rdata_r;
	logic [rcrm_pkg::CFG_DATA_W-1:0]        rdata_nxt;
	logic                                   changed_r;
	logic                                   changed_nxt;
	rcrm_pkg::rcrm_source_type              source_r;
	rcrm_pkg::rcrm_source_type              source_nxt;
	logic                                   hit;
	logic                                   commit;
	logic                                   sel_differs;

	//-------------------------------------------------------------------------
	// access decode
	//-------------------------------------------------------------------------
	// only one word is mapped; all other addresses read zero and drop writes
	always_comb begin
		hit         = (req_r.addr == rcrm_pkg::ROUTE_SELECT_ADDR);
		commit      = (state_r == rcrm_pkg::ST_WAIT) && (cnt_r == 2'h0);
		sel_differs = ((route_word_r ^ req_r.wdata) & rcrm_pkg::SELECTOR_MASK) != 16'h0000;
	end

	//-------------------------------------------------------------------------
	// access sequencer
	//-------------------------------------------------------------------------
	// requests are taken only in idle; a request while busy is ignored
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		req_nxt   = req_r;
		unique case (state_r)
			rcrm_pkg::ST_IDLE: begin
				if (i_cfg_req.en) begin
					req_nxt   = i_cfg_req;
					cnt_nxt   = rcrm_pkg::ACCESS_CYCLES - 2'h1;
					state_nxt = rcrm_pkg::ST_WAIT;
				end
			end
			rcrm_pkg::ST_WAIT: begin
				if (cnt_r == 2'h0) begin
					state_nxt = rcrm_pkg::ST_DONE;
				end else begin
					cnt_nxt = cnt_r - 2'h1;
				end
			end
			rcrm_pkg::ST_DONE: begin
				state_nxt = rcrm_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = rcrm_pkg::ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_r <= rcrm_pkg::ST_IDLE;
			cnt_r   <= 2'h0;
			req_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			req_r   <= req_nxt;
		end
	end

	//-------------------------------------------------------------------------
	// route select word and read data
	//-------------------------------------------------------------------------
	// the whole word is stored, so a write also replaces the bits outside the selectors
	always_comb begin
		route_word_nxt = route_word_r;
		rdata_nxt      = rdata_r;
		if (commit) begin
			if (hit) begin
				rdata_nxt = route_word_r; // read returns the word before this write
				if (req_r.we) begin
					route_word_nxt = req_r.wdata;
				end
			end else begin
				rdata_nxt = rcrm_pkg::UNMAPPED_RDATA;
			end
		end
	end

	// word registers
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			route_word_r <= rcrm_pkg::ROUTE_SELECT_RST;
			rdata_r      <= 16'h0000;
		end else begin
			route_word_r <= route_word_nxt;
			rdata_r      <= rdata_nxt;
		end
	end

	//-------------------------------------------------------------------------
	// routing changed flag
	//-------------------------------------------------------------------------
	// set when a write alters a selector; tile reset clears, set wins
	always_comb begin
		changed_nxt = changed_r;
		if (i_tile_reset) begin
			changed_nxt = 1'b0;
		end
		if (commit && hit && req_r.we && sel_differs) begin
			changed_nxt = 1'b1;
		end
	end

	// flag register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			changed_r <= 1'b0;
		end else begin
			changed_r <= changed_nxt;
		end
	end

	//-------------------------------------------------------------------------
	// decoded source status
	//-------------------------------------------------------------------------
	// registered decode of the stored code for software-visible status
	always_comb begin
		source_nxt = rcrm_pkg::decode_source(rcrm_pkg::extract_code(route_word_nxt));
	end

	// status register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			source_r <= rcrm_pkg::SRC_LOCAL;
		end else begin
			source_r <= source_nxt;
		end
	end

	//-------------------------------------------------------------------------
	// clock multiplexer
	//-------------------------------------------------------------------------
	// steered only by the committed word, never by a pending request
	rcrm_clock_mux u_mux (
		.i_local_ref_clk         (i_local_ref_clk),
		.i_own_ref_clk           (i_own_ref_clk),
		.i_from_north_clk        (i_from_north_clk),
		.i_from_south_clk        (i_from_south_clk),
		.i_source_code           (rcrm_pkg::extract_code(route_word_r)),
		.i_upward_route_choice   (route_word_r[rcrm_pkg::UP_SEL_POS]),
		.i_downward_route_choice (route_word_r[rcrm_pkg::DOWN_SEL_POS]),
		.o_pll_input_clock       (o_pll_input_clock),
		.o_to_north_clk          (o_to_north_clk),
		.o_to_south_clk          (o_to_south_clk)
	);

	//-------------------------------------------------------------------------
	// outputs
	//-------------------------------------------------------------------------
	// handshake is combinational from state, data from flip-flops
	always_comb begin
		o_cfg_rdy               = (state_r == rcrm_pkg::ST_DONE);
		o_cfg_busy              = (state_r != rcrm_pkg::ST_IDLE);
		o_cfg_rdata             = rdata_r;
		o_pll_source            = source_r;
		o_upward_route_choice   = route_word_r[rcrm_pkg::UP_SEL_POS];
		o_downward_route_choice = route_word_r[rcrm_pkg::DOWN_SEL_POS];
		o_own_clock_exported    = route_word_r[rcrm_pkg::UP_SEL_POS] | route_word_r[rcrm_pkg::DOWN_SEL_POS];
		o_route_changed         = changed_r;
	end

endmodule

/* rcrm_route_top_sva.sv */
// assertion checker for the reference clock routing block
module rcrm_route_sva (
	input wire logic                       i_core_clk,
	input wire logic                       i_rst,
	input wire rcrm_pkg::rcrm_cfg_req_type i_cfg_req,
	input wire logic                       o_cfg_rdy,
	input wire logic                       o_cfg_busy,
	input wire logic                       i_local_ref_clk,
	input wire logic                       i_own_ref_clk,
	input wire logic                       i_from_north_clk,
	input wire logic                       i_from_south_clk,
	input wire logic                       o_pll_input_clock,
	input wire logic                       o_to_north_clk,
	input wire logic                       o_to_south_clk,
	input wire rcrm_pkg::rcrm_source_type  o_pll_source,
	input wire logic                       o_upward_route_choice,
	input wire logic                       o_downward_route_choice,
	input wire logic                       o_own_clock_exported,
	input wire logic                       o_route_changed
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	wire logic       take = i_cfg_req.en && !o_cfg_busy && !o_cfg_rdy;
	wire logic       wr04 = take && i_cfg_req.we && (i_cfg_req.addr == 7'h04);
	wire logic [3:0] clks = {i_from_south_clk, i_from_north_clk, i_own_ref_clk, i_local_ref_clk};

	// expected source from a stored word, x positions ignored
	function automatic logic [1:0] src_of(input logic [15:0] w);
		return !w[6] ? 2'h0 : (w[4] ? 2'h3 : (w[5] ? 2'h1 : 2'h2));
	endfunction

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	AST_TAKE_TO_RDY: assert property (take |=> (o_cfg_busy && !o_cfg_rdy) [*2] ##1 (o_cfg_busy && o_cfg_rdy))
		else $error("ready not three cycles after request");
	AST_RDY_ONE: assert property (o_cfg_rdy |=> !o_cfg_rdy && !o_cfg_busy)
		else $error("ready longer than one cycle");
	AST_WR_CHOICES: assert property (wr04 |-> ##3 ((o_upward_route_choice == $past(i_cfg_req.wdata[8], 3))
		&& (o_downward_route_choice == $past(i_cfg_req.wdata[7], 3)))) else $error("route choice bits wrong");
	AST_WR_SOURCE: assert property (wr04 |-> ##3 o_pll_source == src_of($past(i_cfg_req.wdata, 3)))
		else $error("source decode wrong");
	AST_HOLD: assert property (!o_cfg_rdy && !$past(i_rst) |-> $stable({o_pll_source, o_upward_route_choice,
		o_downward_route_choice})) else $error("routing changed outside completion");
	AST_UNMAPPED: assert property (take && i_cfg_req.we && i_cfg_req.addr != 7'h04 |-> ##3 $stable(o_pll_source))
		else $error("unmapped write changed routing");
	AST_NORTH: assert property (o_to_north_clk == (o_upward_route_choice ? i_own_ref_clk : i_from_south_clk))
		else $error("northward path wrong");
	AST_SOUTH: assert property (o_to_south_clk == (o_downward_route_choice ? i_own_ref_clk : i_from_north_clk))
		else $error("southward path wrong");
	AST_PLL: assert property (o_pll_input_clock == clks[o_pll_source])
		else $error("pll input mux wrong");
	AST_CHANGED: assert property ($rose(o_route_changed) |-> o_cfg_rdy)
		else $error("change flag set outside completion");
	AST_EXPORT: assert property (o_own_clock_exported == (o_upward_route_choice || o_downward_route_choice))
		else $error("export status wrong");
endmodule

bind rcrm_route_top rcrm_route_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cfg_req(i_cfg_req),
	.o_cfg_rdy(o_cfg_rdy), .o_cfg_busy(o_cfg_busy), .i_local_ref_clk(i_local_ref_clk),
	.i_own_ref_clk(i_own_ref_clk), .i_from_north_clk(i_from_north_clk), .i_from_south_clk(i_from_south_clk),
	.o_pll_input_clock(o_pll_input_clock), .o_to_north_clk(o_to_north_clk), .o_to_south_clk(o_to_south_clk),
	.o_pll_source(o_pll_source), .o_upward_route_choice(o_upward_route_choice),
	.o_downward_route_choice(o_downward_route_choice), .o_own_clock_exported(o_own_clock_exported),
	.o_route_changed(o_route_changed));

/* rcrm_cfg_master.sv */
// config port master standing in for the fabric controller
module rcrm_cfg_master (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_cfg_rdy,
	input  wire logic [15:0]           i_cfg_rdata,
	output rcrm_pkg::rcrm_cfg_req_type o_cfg_req,
	output logic                       o_tile_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_cfg_req = '0;
	initial o_tile_reset = 1'b0;
	int timeouts = 0; // accesses that never saw ready

	// one access, request held until ready is seen
	task automatic access(input logic we, input logic [6:0] addr, input logic [15:0] wd, output logic [15:0] rd);
		int n = 0;
		@(posedge i_core_clk);
		o_cfg_req <= '{en: 1'b1, we: we, addr: addr, wdata: wd};
		do begin
			@(posedge i_core_clk);
			#1;
			n++;
		end while (i_cfg_rdy !== 1'b1 && n < 20);
		if (i_cfg_rdy !== 1'b1) begin
			timeouts++;
		end
		rd = i_cfg_rdata;
		@(posedge i_core_clk);
		o_cfg_req <= '{en: 1'b0, we: ~we, addr: ~addr, wdata: ~wd}; // released lines toggle
	endtask

	// selector change keeping the other bits, then tile reset
	task automatic rmw(input logic [15:0] sel);
		logic [15:0] w;
		access(1'b0, 7'h04, 16'h0000, w);
		access(1'b1, 7'h04, (w & ~rcrm_pkg::SELECTOR_MASK) | (sel & rcrm_pkg::SELECTOR_MASK), w);
		@(posedge i_core_clk);
		o_tile_reset <= 1'b1;
		@(posedge i_core_clk);
		o_tile_reset <= 1'b0;
	endtask
endmodule

/* test_rcrm_route_top.sv */
// self-checking testbench for the reference clock routing block
module test_rcrm_route_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [15:0] w; logic [1:0] src; logic up; logic dn;} rcrm_row_type;
	localparam rcrm_row_type ROWS [10] = '{'{16'h0040, 2'h2, 1'b0, 1'b0}, '{16'h0060, 2'h1, 1'b0, 1'b0},
		'{16'h0050, 2'h3, 1'b0, 1'b0}, '{16'h0070, 2'h3, 1'b0, 1'b0}, '{16'h0030, 2'h0, 1'b0, 1'b0},
		'{16'h0010, 2'h0, 1'b0, 1'b0}, '{16'h0020, 2'h0, 1'b0, 1'b0}, '{16'h0100, 2'h0, 1'b1, 1'b0},
		'{16'h0080, 2'h0, 1'b0, 1'b1}, '{16'h01c0, 2'h2, 1'b1, 1'b1}};
	logic                       i_core_clk, i_rst, cfg_rdy, cfg_busy, pll_clk, to_n, to_s;
	logic                       up, dn, exported, changed, tile_reset;
	logic [3:0]                 clks;
	logic [15:0]                cfg_rdata, rd;
	rcrm_pkg::rcrm_cfg_req_type cfg_req;
	rcrm_pkg::rcrm_source_type  src;
	int                         num_errors = 0;
	int                         check_count = 0;

	rcrm_route_top dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cfg_req(cfg_req), .o_cfg_rdy(cfg_rdy),
		.o_cfg_rdata(cfg_rdata), .o_cfg_busy(cfg_busy), .i_tile_reset(tile_reset), .i_local_ref_clk(clks[0]),
		.i_own_ref_clk(clks[1]), .i_from_north_clk(clks[2]), .i_from_south_clk(clks[3]),
		.o_pll_input_clock(pll_clk), .o_to_north_clk(to_n), .o_to_south_clk(to_s), .o_pll_source(src),
		.o_upward_route_choice(up), .o_downward_route_choice(dn), .o_own_clock_exported(exported),
		.o_route_changed(changed));
	rcrm_cfg_master m (.i_core_clk(i_core_clk), .i_cfg_rdy(cfg_rdy), .i_cfg_rdata(cfg_rdata),
		.o_cfg_req(cfg_req), .o_tile_reset(tile_reset));

	// ------------------------------------------------------------------
	// clock, compare, verdict, watchdog
	// ------------------------------------------------------------------
	initial begin
		i_core_clk = 1'b0;
		forever #2 i_core_clk = ~i_core_clk;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		if (num_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		summarize();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		i_rst = 1'b1;
		clks = 4'h0;
		repeat (6) @(posedge i_core_clk);
		i_rst <= 1'b0;
		m.access(1'b0, 7'h04, 16'h0000, rd);
		check("reset word", rd, 16'h0000);
		check("reset changed", changed, 1'b0);
		foreach (ROWS[i]) begin
			m.access(1'b1, 7'h04, ROWS[i].w, rd);
			check("old word", rd, i == 0 ? 16'h0000 : ROWS[i-1].w);
			for (int k = 0; k < 4; k++) begin
				@(posedge i_core_clk);
				clks <= 4'h1 << k;
				#1;
				check("source", src, ROWS[i].src);
				check("pll clk", pll_clk, clks[ROWS[i].src]);
				check("north", to_n, ROWS[i].up ? clks[1] : clks[3]);
				check("south", to_s, ROWS[i].dn ? clks[1] : clks[2]);
			end
			check("up", up, ROWS[i].up);
			check("down", dn, ROWS[i].dn);
			check("exported", exported, ROWS[i].up | ROWS[i].dn);
			check("changed", changed, 1'b1);
		end
		// awkward cases: kept bits, tile reset, unmapped place, mid-run reset
		m.access(1'b1, 7'h04, 16'ha50f, rd);
		m.rmw(16'h0150);
		#1;
		check("changed", changed, 1'b0);
		m.access(1'b0, 7'h04, 16'h0000, rd);
		check("rmw word", rd, 16'ha55f);
		m.access(1'b1, 7'h05, 16'h0000, rd);
		m.access(1'b0, 7'h05, 16'h0000, rd);
		check("unmapped", rd, 16'h0000);
		check("source kept", src, 2'h3);
		check("up kept", up, 1'b1);
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		m.access(1'b0, 7'h04, 16'h0000, rd);
		check("reset word", rd, 16'h0000);
		check("access timeouts", 16'(m.timeouts), 16'h0000);
		summarize();
	end
endmodule
